/* File: bench/lioplo_chk.sv */
// Purpose: port checks of the local i/o block
// Assumes: one clock, async low reset
// Notes:   bound into lioplo_top
`timescale 1ns/1ps
module lioplo_chk #(
   parameter int MS_CYCLES = 100000
)(
   input wire logic       clk_in,
   input wire logic       rst_b_in,
   input wire logic       sync_rst_in,
   input wire logic [1:0] motion_mode_in,
   input wire logic [7:0] local_out_in,
   input wire logic [7:0] shared_pin_out,
   input wire logic [7:0] shared_pin_oe_out,
   input wire logic [7:0] local_in_out,
   input wire logic       supply_present_out,
   input wire logic       supply_fault_out,
   input wire logic [1:0] probe_valid_out,
   input wire logic [1:0] probe_event_out,
   input wire logic       switching_level_out,
   input wire logic       switching_settled_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   AST_PIN_MASK: assert property ((shared_pin_out & ~shared_pin_oe_out) == 8'h00)
      else $error("input pin driven");
   AST_OE_RUN: assert property (((shared_pin_oe_out + 8'h01) & shared_pin_oe_out) == 8'h00)
      else $error("outputs not from pin 1 up");
   AST_IN_MASK: assert property ((local_in_out & shared_pin_oe_out) == 8'h00)
      else $error("input seen on output pin");
   AST_SUP_EXCL: assert property (!(supply_present_out && supply_fault_out))
      else $error("supply both present and faulty");
   AST_PRB_EVT: assert property (probe_event_out[0] == $rose(probe_valid_out[0]))
      else $error("probe event not at valid rise");
   AST_SW_RISE: assert property ((motion_mode_in != 2'h0 && $past(motion_mode_in) == 2'h0
      && !sync_rst_in) |=> switching_level_out) else $error("switching not raised");
   AST_SW_FALL: assert property ((motion_mode_in == 2'h0 && $past(motion_mode_in) != 2'h0
      && !sync_rst_in) |=> !switching_level_out) else $error("switching not dropped");
   AST_SW_SETTLE: assert property (($changed(switching_level_out) && !$past(sync_rst_in))
      |-> !switching_settled_out) else $error("settled during delay");
   AST_PIN_LAT: assert property (($stable(shared_pin_oe_out) && !$past(sync_rst_in))
      |-> shared_pin_out[7:2] == ($past(local_out_in[7:2]) & shared_pin_oe_out[7:2]))
      else $error("pin drive wrong");
   cover property (probe_event_out[0]);
   cover property ($rose(switching_level_out));
   cover property (supply_fault_out);
endmodule
bind lioplo_top lioplo_chk #(.MS_CYCLES(MS_CYCLES)) i_lioplo_chk (.clk_in, .rst_b_in,
   .sync_rst_in, .motion_mode_in, .local_out_in, .shared_pin_out, .shared_pin_oe_out,
   .local_in_out, .supply_present_out, .supply_fault_out, .probe_valid_out,
   .probe_event_out, .switching_level_out, .switching_settled_out);

/* File: bench/lioplo_far_model.sv */
// Purpose: devices on the shared pins, local probes and 24 v supply
// Assumes: bench sets what outside devices drive
// Notes:   a pin the block drives shows its level, else the device level
`timescale 1ns/1ps
module lioplo_far_model (
   input wire logic  [7:0] shared_pin_out,
   input wire logic  [7:0] shared_pin_oe_out,
   input wire logic  [7:0] ext_pin_in,
   input wire logic  [1:0] probe_lvl_in,
   input wire logic        sup_on_in,
   output logic      [7:0] pin_lvl_out,
   output logic      [1:0] probe_out,
   output logic            supply_out
);
   assign pin_lvl_out = (shared_pin_out & shared_pin_oe_out) | (ext_pin_in & ~shared_pin_oe_out);
   assign probe_out = probe_lvl_in;
   assign supply_out = sup_on_in;
endmodule

/* File: bench/tb_lioplo_top.sv */
// Purpose: self-checking bench of the local i/o block
// Assumes: ms tick shortened to 10 cycles
// Notes:   pin drive checked each cycle against a model, the rest inline
`timescale 1ns/1ps
module tb_lioplo_top;
   logic clk_in = 0, rst_b_in = 0, sync_rst_in = 0, cfg_load_in = 0, pulse_width_in = 0;
   logic supply_monitor_enable_in = 1, probe1_location_in = 0, probe2_location_in = 0;
   logic probe1_active_level_in = 0, probe2_active_level_in = 0, sup_on = 1, supply_24v_in;
   logic [3:0] local_output_count_in = 0, switching_output_select_in = 0;
   logic [10:0] probe1_input_select_in = 0, probe2_input_select_in = 0;
   logic [10:0] remote_physical_count_in = 11'h100;
   logic [6:0] switching_device_delay_in = 0;
   logic [1:0] pulse_width_output_select_in = 0, motion_mode_in = 0, probe_lvl = 0;
   logic [7:0] local_out_in = 0, ext = 0, msk, shared_pin_in, shared_pin_out;
   logic [7:0] shared_pin_oe_out, local_in_out;
   logic [1023:0] remote_inputs_in = '0;
   logic [1:0] local_probe_in, probe_valid_out, probe_event_out, probe_logical_out;
   logic supply_present_out, supply_fault_out, switching_level_out, switching_settled_out;
   int num_errors = 0, check_count = 0, seed = 49299, n, t;
   int m_n = 0, m_sw = 0, m_pw = 0, m_prev = 0, m_lvl = 0, m_k;
   logic [7:0] m_drv;
   logic [7:0] q_pin[$];

   always #5 clk_in = ~clk_in;

   lioplo_top #(.MS_CYCLES(10)) i_lioplo_top (.clk_in, .rst_b_in, .sync_rst_in, .cfg_load_in,
      .local_output_count_in, .supply_monitor_enable_in, .probe1_input_select_in,
      .probe2_input_select_in, .probe1_location_in, .probe2_location_in,
      .probe1_active_level_in, .probe2_active_level_in, .switching_output_select_in,
      .switching_device_delay_in, .pulse_width_output_select_in, .local_out_in,
      .pulse_width_in, .motion_mode_in, .remote_inputs_in, .remote_physical_count_in,
      .shared_pin_in, .local_probe_in, .supply_24v_in, .shared_pin_out, .shared_pin_oe_out,
      .local_in_out, .supply_present_out, .supply_fault_out, .probe_valid_out,
      .probe_event_out, .probe_logical_out, .switching_level_out, .switching_settled_out);
   lioplo_far_model i_lioplo_far_model (.shared_pin_out, .shared_pin_oe_out, .ext_pin_in(ext),
      .probe_lvl_in(probe_lvl), .sup_on_in(sup_on), .pin_lvl_out(shared_pin_in),
      .probe_out(local_probe_in), .supply_out(supply_24v_in));

   // pin drive model: expected drive queued at each edge, compared half a cycle later
   always @(posedge clk_in) begin
      m_drv = 8'h00;
      for (m_k = 0; m_k < m_n; m_k++) begin
         m_drv[m_k] = local_out_in[m_k] | (m_sw == m_k + 1 && m_lvl != 0)
                    | (m_pw == m_k + 1 && pulse_width_in);
      end
      q_pin.push_back(rst_b_in ? m_drv : 8'h00);
      if (!rst_b_in || sync_rst_in) begin
         m_n = 0;
         m_sw = 0;
         m_pw = 0;
         m_prev = 0;
         m_lvl = 0;
      end else begin
         if (cfg_load_in) begin
            m_n = local_output_count_in > 4'h8 ? 8 : int'(local_output_count_in);
            m_sw = switching_output_select_in > m_n ? 0 : int'(switching_output_select_in);
            m_pw = pulse_width_output_select_in > 2'h2 ? 0 : int'(pulse_width_output_select_in);
         end
         if (motion_mode_in != 2'h0 && m_prev == 0) begin
            m_lvl = 1;
         end
         if (motion_mode_in == 2'h0 && m_prev != 0) begin
            m_lvl = 0;
         end
         m_prev = (motion_mode_in != 2'h0);
      end
   end

   always @(negedge clk_in) begin
      if (q_pin.size() != 0) begin
         chk_pin(shared_pin_out, q_pin.pop_front());
      end
   end

   task finish_test;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task chk_pin(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: pin drive %h expected %h", $time, got, exp);
      end
   endtask

   task tick(input int k);
      repeat (k) @(posedge clk_in);
      #1;
   endtask

   // ch 0/1 waits for probe valid, 2 for switching settled
   task wt(input int ch, input int lim, output int c);
      c = 0;
      while ((ch == 2 ? switching_settled_out : probe_valid_out[ch[0]]) !== 1'b1) begin
         tick(1);
         c++;
         if (c > lim) begin
            chk(8'h00, 8'h01);
            finish_test;
         end
      end
   endtask

   task cfg(input int nn, input int sw, input int pw);
      @(posedge clk_in);
      local_output_count_in <= 4'(nn);
      supply_monitor_enable_in <= (nn != 0);
      switching_output_select_in <= 4'(sw);
      pulse_width_output_select_in <= 2'(pw);
      cfg_load_in <= 1'b1;
      @(posedge clk_in);
      cfg_load_in <= 1'b0;
      tick(1);
   endtask

   initial begin
      repeat (4) @(posedge clk_in);
      rst_b_in <= 1'b1;
      tick(6);
      chk(shared_pin_oe_out, 8'h00);
      chk({6'h00, supply_present_out, switching_settled_out}, 8'h03);
      for (n = 0; n < 10; n++) begin
         cfg(n, 0, 0);
         msk = 8'((1 << (n > 8 ? 8 : n)) - 1);
         chk(shared_pin_oe_out, msk);
         @(posedge clk_in);
         local_out_in <= 8'($random(seed));
         ext <= 8'($random(seed));
         sup_on <= 1'($random(seed));
         tick(6);
         chk(shared_pin_out, local_out_in & msk);
         chk(local_in_out, ext & ~msk);
         chk({6'h00, supply_fault_out, supply_present_out},
             n != 0 ? {6'h00, !sup_on, sup_on} : 8'h00);
      end
      $display("test pins done");
      @(posedge clk_in);
      local_out_in <= 8'h00;
      probe1_input_select_in <= 11'h005;
      probe2_input_select_in <= 11'h002;
      probe2_location_in <= 1'b1;
      probe2_active_level_in <= 1'b1;
      probe_lvl <= 2'h3;
      cfg(8, 0, 0);
      @(posedge clk_in);
      remote_inputs_in[4] <= 1'b1;
      tick(150);
      chk({6'h00, probe_valid_out}, 8'h00);
      @(posedge clk_in);
      remote_inputs_in[4] <= 1'b0;
      tick(20);
      @(posedge clk_in);
      remote_inputs_in[4] <= 1'b1;
      probe_lvl <= 2'h1;
      wt(0, 240, t);
      chk({7'h00, t >= 199 && t <= 220}, 8'h01);
      chk({6'h00, probe_logical_out, probe_event_out[0]}, 8'h01);
      wt(1, 40, t);
      chk({5'h00, probe_event_out[1], probe_valid_out}, 8'h07);
      @(posedge clk_in);
      probe1_input_select_in <= 11'h12c;
      cfg(8, 0, 0);
      chk({6'h00, probe_logical_out}, 8'h01);
      @(posedge clk_in);
      probe1_input_select_in <= 11'h401;
      probe1_active_level_in <= 1'b1;
      cfg(8, 0, 0);
      tick(230);
      chk({5'h00, probe_logical_out, probe_valid_out[0]}, 8'h00);
      $display("test probes done");
      @(posedge clk_in);
      switching_device_delay_in <= 7'h03;
      cfg(8, 1, 2);
      for (n = 1; n < 4; n++) begin
         @(posedge clk_in);
         motion_mode_in <= 2'(n);
         tick(2);
         chk({6'h00, switching_level_out, switching_settled_out}, 8'h02);
         wt(2, 40, t);
         chk({6'h00, t >= 15 && t <= 32, shared_pin_out[0]}, 8'h03);
         @(posedge clk_in);
         motion_mode_in <= 2'h0;
         tick(3);
         chk(shared_pin_out & 8'h01, 8'h00);
         wt(2, 40, t);
      end
      for (n = 0; n < 4; n++) begin
         cfg(8, 0, n);
         @(posedge clk_in);
         pulse_width_in <= 1'b1;
         motion_mode_in <= 2'h1;
         tick(3);
         chk(shared_pin_out & 8'h03, n == 1 ? 8'h01 : n == 2 ? 8'h02 : 8'h00);
         @(posedge clk_in);
         pulse_width_in <= 1'b0;
         motion_mode_in <= 2'h0;
         tick(2);
      end
      cfg(8, 1, 1);
      @(posedge clk_in);
      pulse_width_in <= 1'b1;
      tick(2);
      chk(shared_pin_out & 8'h01, 8'h01);
      @(posedge clk_in);
      pulse_width_in <= 1'b0;
      motion_mode_in <= 2'h2;
      tick(3);
      chk(shared_pin_out & 8'h01, 8'h01);
      $display("test switching done");
      @(posedge clk_in);
      sync_rst_in <= 1'b1;
      @(posedge clk_in);
      sync_rst_in <= 1'b0;
      tick(2);
      chk({shared_pin_oe_out[6:0], switching_settled_out}, 8'h01);
      $display("test sync reset done");
      finish_test;
   end
endmodule

/* File: design/lioplo_consts.svh */
// Purpose: limits, reset values and timing counts of the local i/o block
// Assumes: one 100 MHz system clock
// Notes:   included by the block's top module
`ifndef LIOPLO_CONSTS_SVH
`define LIOPLO_CONSTS_SVH

`define LIOPLO_PINS           8
`define LIOPLO_OUTCNT_MAX     4'h8
`define LIOPLO_OUTCNT_RST     4'h0
`define LIOPLO_SUPMON_RST     1'b1
`define LIOPLO_PRBSEL_RST     11'h000
`define LIOPLO_PRBSEL_MAX     11'h400
`define LIOPLO_LOCSEL_MAX     11'h002
`define LIOPLO_LOC_RST        1'b0
`define LIOPLO_POL_RST        1'b0
`define LIOPLO_SWSEL_RST      4'h0
`define LIOPLO_SWDLY_RST      7'h00
`define LIOPLO_SWDLY_MAX      7'h64
`define LIOPLO_PWMSEL_RST     2'h0
`define LIOPLO_PWMSEL_MAX     2'h2
`define LIOPLO_CLK_NS         10
`define LIOPLO_MS_NS          1000000
`define LIOPLO_MS_CYC         (`LIOPLO_MS_NS / `LIOPLO_CLK_NS)
`define LIOPLO_PRB_MIN_MS     20
`define LIOPLO_PRB_MIN_TICKS  5'((`LIOPLO_PRB_MIN_MS) + 1)
`define LIOPLO_REMOTE_N       1024

`endif

/* File: design/lioplo_pkg.sv */
// Purpose: types of the local i/o, probe and laser output block
// Assumes: constants come from lioplo_consts.svh
// Notes:   switching states are one-hot
package lioplo_pkg;
   typedef enum logic [1:0] {
      MOT_RAPID  = 2'h0,
      MOT_LINEAR = 2'h1,
      MOT_CW     = 2'h2,
      MOT_CCW    = 2'h3
   } lioplo_motion_e;

   typedef enum logic {LOC_REMOTE = 1'b0, LOC_LOCAL = 1'b1} lioplo_loc_e;
   typedef enum logic {POL_POS = 1'b0, POL_NEG = 1'b1} lioplo_pol_e;

   typedef enum logic [3:0] {
      SW_OFF      = 4'h1,
      SW_ON_WAIT  = 4'h2,
      SW_ON       = 4'h4,
      SW_OFF_WAIT = 4'h8
   } lioplo_sw_e;
endpackage

/* File: design/lioplo_top.sv */
// Purpose: local shared pins, two probe channels, synchronized switching and pwm routing
// Assumes: remote inputs, motion mode and pwm come from logic on clk_in
// Notes:   pins, local probes and supply sense pass a three-flop filter
// Contract
// - first N shared pins outputs, rest inputs
// - outputs numbered 1 up, pin k input 8+k
// - supply monitor enable, default on, detects 24V
// - probe select: 1-1024 remote, 1-2 local, 0 none
// - selects above physical count are logical inputs
// - probe polarity positive or negative, default positive
// - probe valid only after 20 ms active
// - switching select 0..N, default 0 none
// - rapid to interpolation asserts switching output
// - interpolation to rapid deasserts switching output
// - switching device delay 0-100 ms, default 0
// - pwm select: 0 none, 1 pin1, 2 pin2
// - pwm and switching may share one pin
// - probe location remote or local, default remote
`timescale 1ns/1ps
`include "lioplo_consts.svh"

module lioplo_top
   import lioplo_pkg::*;
#(
   parameter int MS_CYCLES = `LIOPLO_MS_CYC
)(
   input  wire logic            clk_in,
   input  wire logic            rst_b_in,
   input  wire logic            sync_rst_in,
   input  wire logic            cfg_load_in,
   input  wire logic [3:0]      local_output_count_in,
   input  wire logic            supply_monitor_enable_in,
   input  wire logic [10:0]     probe1_input_select_in,
   input  wire logic [10:0]     probe2_input_select_in,
   input  wire logic            probe1_location_in,
   input  wire logic            probe2_location_in,
   input  wire logic            probe1_active_level_in,
   input  wire logic            probe2_active_level_in,
   input  wire logic [3:0]      switching_output_select_in,
   input  wire logic [6:0]      switching_device_delay_in,
   input  wire logic [1:0]      pulse_width_output_select_in,
   input  wire logic [7:0]      local_out_in,
   input  wire logic            pulse_width_in,
   input  wire logic [1:0]      motion_mode_in,
   input  wire logic [1023:0]   remote_inputs_in,
   input  wire logic [10:0]     remote_physical_count_in,
   input  wire logic [7:0]      shared_pin_in,
   input  wire logic [1:0]      local_probe_in,
   input  wire logic            supply_24v_in,
   output logic [7:0]           shared_pin_out,
   output logic [7:0]           shared_pin_oe_out,
   output logic [7:0]           local_in_out,
   output logic                 supply_present_out,
   output logic                 supply_fault_out,
   output logic [1:0]           probe_valid_out,
   output logic [1:0]           probe_event_out,
   output logic [1:0]           probe_logical_out,
   output logic                 switching_level_out,
   output logic                 switching_settled_out
);

   localparam int MSW = $clog2(MS_CYCLES + 1);

   // probe level after polarity; inactive when no usable input is selected
   function automatic logic probe_active(input logic [10:0]   sel,
                                         input lioplo_loc_e   loc,
                                         input lioplo_pol_e   pol,
                                         input logic [1023:0] rem,
                                         input logic [1:0]    lp);
      logic raw;
      logic ok;
      raw = 1'b0;
      ok  = 1'b0;
      if (loc == LOC_LOCAL) begin
         ok  = (sel != 11'h000) && (sel <= `LIOPLO_LOCSEL_MAX);
         raw = (sel == 11'h002) ? lp[1] : lp[0];
      end else begin
         ok  = (sel != 11'h000) && (sel <= `LIOPLO_PRBSEL_MAX);
         raw = rem[10'(sel - 11'h001)];
      end
      probe_active = ok & (raw ^ (pol == POL_NEG));
   endfunction

   // settings
   logic [3:0]       oc_r;
   logic             supmon_r;
   logic [3:0]       sw_sel_r;
   logic [6:0]       sw_dly_r;
   logic [1:0]       pwm_sel_r;
   logic [1:0][10:0] prb_sel_r;
   logic [1:0]       prb_loc_r;
   logic [1:0]       prb_pol_r;

   wire [3:0] oc_in   = (local_output_count_in > `LIOPLO_OUTCNT_MAX) ?
                        `LIOPLO_OUTCNT_MAX : local_output_count_in;
   wire [3:0] sw_in   = (switching_output_select_in > oc_in) ?
                        `LIOPLO_SWSEL_RST : switching_output_select_in;
   wire [6:0] dly_in  = (switching_device_delay_in > `LIOPLO_SWDLY_MAX) ?
                        `LIOPLO_SWDLY_MAX : switching_device_delay_in;
   wire [1:0] pwm_in  = (pulse_width_output_select_in > `LIOPLO_PWMSEL_MAX) ?
                        `LIOPLO_PWMSEL_RST : pulse_width_output_select_in;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         oc_r      <= `LIOPLO_OUTCNT_RST;
         supmon_r  <= `LIOPLO_SUPMON_RST;
         sw_sel_r  <= `LIOPLO_SWSEL_RST;
         sw_dly_r  <= `LIOPLO_SWDLY_RST;
         pwm_sel_r <= `LIOPLO_PWMSEL_RST;
         prb_sel_r <= {2{`LIOPLO_PRBSEL_RST}};
         prb_loc_r <= {2{`LIOPLO_LOC_RST}};
         prb_pol_r <= {2{`LIOPLO_POL_RST}};
      end else if (sync_rst_in) begin
         oc_r      <= `LIOPLO_OUTCNT_RST;
         supmon_r  <= `LIOPLO_SUPMON_RST;
         sw_sel_r  <= `LIOPLO_SWSEL_RST;
         sw_dly_r  <= `LIOPLO_SWDLY_RST;
         pwm_sel_r <= `LIOPLO_PWMSEL_RST;
         prb_sel_r <= {2{`LIOPLO_PRBSEL_RST}};
         prb_loc_r <= {2{`LIOPLO_LOC_RST}};
         prb_pol_r <= {2{`LIOPLO_POL_RST}};
      end else if (cfg_load_in) begin
         oc_r      <= oc_in;
         supmon_r  <= supply_monitor_enable_in;
         sw_sel_r  <= sw_in;
         sw_dly_r  <= dly_in;
         pwm_sel_r <= pwm_in;
         prb_sel_r <= {probe2_input_select_in, probe1_input_select_in};
         prb_loc_r <= {probe2_location_in, probe1_location_in};
         prb_pol_r <= {probe2_active_level_in, probe1_active_level_in};
      end
   end

   // three-flop filter: pins 7:0, local probes 9:8, supply sense 10
   logic [10:0] sy1_r;
   logic [10:0] sy2_r;
   logic [10:0] sy3_r;
   logic [10:0] flt_r;
   wire  [10:0] flt_nxt = (sy2_r & sy3_r) | (flt_r & ~(sy2_r ^ sy3_r));

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sy1_r <= 11'h000;
         sy2_r <= 11'h000;
         sy3_r <= 11'h000;
         flt_r <= 11'h000;
      end else begin
         sy1_r <= {supply_24v_in, local_probe_in, shared_pin_in};
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
         flt_r <= flt_nxt;
      end
   end

   // millisecond tick
   logic [MSW-1:0] ms_cnt_r;
   logic           tick_r;
   wire            ms_wrap = (ms_cnt_r == MSW'(MS_CYCLES - 1));

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ms_cnt_r <= '0;
         tick_r   <= 1'b0;
      end else begin
         ms_cnt_r <= (ms_wrap || sync_rst_in) ? '0 : ms_cnt_r + MSW'(1);
         tick_r   <= ms_wrap && !sync_rst_in;
      end
   end

   // shared pins
   wire [7:0] pin_is_out;
   wire [7:0] pin_val;
   logic      sw_level_r;

   for (genvar k = 0; k < `LIOPLO_PINS; k++) begin : g_pin
      wire sw_hit  = (sw_sel_r == 4'(k + 1));
      wire pwm_hit = ({2'h0, pwm_sel_r} == 4'(k + 1));
      assign pin_is_out[k] = (4'(k) < oc_r);
      // switching and pwm both or into the pin when they share it
      assign pin_val[k] = local_out_in[k] | (sw_hit & sw_level_r)
                        | (pwm_hit & pulse_width_in);
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         shared_pin_out    <= 8'h00;
         shared_pin_oe_out <= 8'h00;
         local_in_out      <= 8'h00;
      end else begin
         shared_pin_out    <= pin_val & pin_is_out;
         shared_pin_oe_out <= pin_is_out;
         local_in_out      <= flt_r[7:0] & ~pin_is_out;
      end
   end

   // 24 V supply monitor
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         supply_present_out <= 1'b0;
         supply_fault_out   <= 1'b0;
      end else begin
         supply_present_out <= supmon_r & flt_r[10];
         supply_fault_out   <= supmon_r & ~flt_r[10];
      end
   end

   // probe channels
   for (genvar c = 0; c < 2; c++) begin : g_prb
      logic [4:0] cnt_r;
      logic       vld_r;
      logic       evt_r;
      logic       lgc_r;
      wire act = probe_active(prb_sel_r[c], lioplo_loc_e'(prb_loc_r[c]),
                              lioplo_pol_e'(prb_pol_r[c]),
                              remote_inputs_in, flt_r[9:8]);
      wire full = (cnt_r == `LIOPLO_PRB_MIN_TICKS);
      // one extra tick covers a partial first millisecond
      always_ff @(posedge clk_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            cnt_r <= 5'h00;
            vld_r <= 1'b0;
            evt_r <= 1'b0;
            lgc_r <= 1'b0;
         end else begin
            if (!act || sync_rst_in) begin
               cnt_r <= 5'h00;
            end else if (tick_r && !full) begin
               cnt_r <= cnt_r + 5'h01;
            end
            vld_r <= full && act;
            evt_r <= full && act && !vld_r;
            lgc_r <= !prb_loc_r[c]
                                 && (prb_sel_r[c] > remote_physical_count_in)
                                 && (prb_sel_r[c] <= `LIOPLO_PRBSEL_MAX);
         end
      end
   end

   // each output vector has a single driver
   assign probe_valid_out   = {g_prb[1].vld_r, g_prb[0].vld_r};
   assign probe_event_out   = {g_prb[1].evt_r, g_prb[0].evt_r};
   assign probe_logical_out = {g_prb[1].lgc_r, g_prb[0].lgc_r};

   // synchronized switching
   lioplo_sw_e sw_st_r;
   lioplo_sw_e sw_st_nxt;
   logic       interp_r;
   logic [6:0] dly_cnt_r;
   wire        interp  = (lioplo_motion_e'(motion_mode_in) != MOT_RAPID);
   wire        go_on   = interp && !interp_r;
   wire        go_off  = !interp && interp_r;
   wire        dly_end = (dly_cnt_r >= sw_dly_r);

   always_comb begin
      sw_st_nxt = sw_st_r;
      case (sw_st_r)
         SW_OFF:      sw_st_nxt = SW_OFF;
         SW_ON_WAIT:  sw_st_nxt = dly_end ? SW_ON : SW_ON_WAIT;
         SW_ON:       sw_st_nxt = SW_ON;
         SW_OFF_WAIT: sw_st_nxt = dly_end ? SW_OFF : SW_OFF_WAIT;
         default:     sw_st_nxt = SW_OFF;
      endcase
      if (go_on) begin
         sw_st_nxt = SW_ON_WAIT;
      end else if (go_off) begin
         sw_st_nxt = SW_OFF_WAIT;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sw_st_r    <= SW_OFF;
         interp_r   <= 1'b0;
         sw_level_r <= 1'b0;
         dly_cnt_r  <= 7'h00;
      end else if (sync_rst_in) begin
         sw_st_r    <= SW_OFF;
         interp_r   <= 1'b0;
         sw_level_r <= 1'b0;
         dly_cnt_r  <= 7'h00;
      end else begin
         sw_st_r  <= sw_st_nxt;
         interp_r <= interp;
         if (go_on) begin
            sw_level_r <= 1'b1;
         end else if (go_off) begin
            sw_level_r <= 1'b0;
         end
         if (go_on || go_off) begin
            dly_cnt_r <= 7'h00;
         end else if (tick_r && !dly_end) begin
            dly_cnt_r <= dly_cnt_r + 7'h01;
         end
      end
   end

   assign switching_level_out   = sw_level_r;
   assign switching_settled_out = (sw_st_r == SW_ON) || (sw_st_r == SW_OFF);

endmodule
